// File: core/sbst_pkg.sv
/*
 * constants, state and instruction types for the sram boundary-scan tap.
 * assumes a single 100 mhz system clock that oversamples the test clock.
 */
package sbst_pkg;
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN = 85;
    // output-enable cell is the 85th cell, the one nearest the serial input
    localparam int OE_CELL = 84;
    // identification value is arbitrary; bit 0 marks a present id register
    localparam logic [31:0] ID_CODE = 32'h0A5C_3E01;
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_PRELOAD = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TCK_MIN_PERIOD_NS = 50;
    localparam int TCK_MIN_PERIOD_CYC = (TCK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sbst_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_ID = 2'h1,
        SEL_BSR = 2'h2
    } sbst_sel_t;
endpackage

// File: core/sbst_sync.sv
/*
 * two-flop synchroniser, width set by parameter.
 * assumes inputs are asynchronous to clk; only the second stage is read outside.
 */
`timescale 1ns/1ps
module sbst_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= INIT;
            q <= INIT;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// File: core/sbst_tap.sv
/*
 * boundary-scan test access port of a synchronous sram: tap state machine,
 * instruction, bypass, identification and boundary scan registers.
 * assumes the test clock, mode select, data in and the pin ring are all
 * asynchronous to clk and are oversampled; the test clock is far slower.
 */
`timescale 1ns/1ps
module sbst_tap #(
    parameter int BSR_W = sbst_pkg::BSR_LEN,
    parameter logic [31:0] ID_VALUE = sbst_pkg::ID_CODE
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic test_clk,
    input wire logic test_mode_sel,
    input wire logic test_data_in,
    input wire logic [BSR_W-1:0] ring_in,
    output logic test_data_out,
    output logic test_data_out_oe_n,
    output logic [BSR_W-1:0] ring_preload,
    output logic ring_drive,
    output logic ring_hiz,
    output logic [2:0] active_instr
);
    // synchronised pins
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_d;
    logic [BSR_W-1:0] ring_s;
    logic tck_rise;
    logic tck_fall;

    // tap state
    sbst_pkg::sbst_state_t state;
    sbst_pkg::sbst_state_t next_state;

    // scan registers
    logic [sbst_pkg::IR_LEN-1:0] ir_shift;
    logic [sbst_pkg::IR_LEN-1:0] ir_active;
    logic bypass_bit;
    logic [sbst_pkg::ID_LEN-1:0] id_shift;
    logic [BSR_W-1:0] bsr_shift;
    logic [BSR_W-1:0] bsr_latch;
    sbst_pkg::sbst_sel_t dr_sel;
    logic bsr_update_ok;
    logic next_tdo;

    // mode select and data sampled with the same latency as the test clock
    sbst_sync #(
        .WIDTH(3),
        .INIT(3'h2)
    ) u_pin_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({test_clk, test_mode_sel, test_data_in}),
        .q({tck_s, tms_s, tdi_s})
    );

    // ring values move with the memory clock; capture is only as good as
    // the controller's hold-still around the capture point
    sbst_sync #(
        .WIDTH(BSR_W),
        .INIT('0)
    ) u_ring_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(ring_in),
        .q(ring_s)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= tck_s;
        end
    end

    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    // tap transition table
    function automatic sbst_pkg::sbst_state_t tap_next(
        input sbst_pkg::sbst_state_t cur,
        input logic tms
    );
        sbst_pkg::sbst_state_t nxt;
        nxt = sbst_pkg::ST_RESET;
        case (cur)
            sbst_pkg::ST_RESET: begin
                nxt = tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
            end
            sbst_pkg::ST_IDLE: begin
                nxt = tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            end
            sbst_pkg::ST_SEL_DR: begin
                nxt = tms ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
            end
            sbst_pkg::ST_CAP_DR: begin
                nxt = tms ? sbst_pkg::ST_EXIT1_DR : sbst_pkg::ST_SHIFT_DR;
            end
            sbst_pkg::ST_SHIFT_DR: begin
                nxt = tms ? sbst_pkg::ST_EXIT1_DR : sbst_pkg::ST_SHIFT_DR;
            end
            sbst_pkg::ST_EXIT1_DR: begin
                nxt = tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PAUSE_DR;
            end
            sbst_pkg::ST_PAUSE_DR: begin
                nxt = tms ? sbst_pkg::ST_EXIT2_DR : sbst_pkg::ST_PAUSE_DR;
            end
            sbst_pkg::ST_EXIT2_DR: begin
                nxt = tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SHIFT_DR;
            end
            sbst_pkg::ST_UPD_DR: begin
                nxt = tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            end
            sbst_pkg::ST_SEL_IR: begin
                nxt = tms ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAP_IR;
            end
            sbst_pkg::ST_CAP_IR: begin
                nxt = tms ? sbst_pkg::ST_EXIT1_IR : sbst_pkg::ST_SHIFT_IR;
            end
            sbst_pkg::ST_SHIFT_IR: begin
                nxt = tms ? sbst_pkg::ST_EXIT1_IR : sbst_pkg::ST_SHIFT_IR;
            end
            sbst_pkg::ST_EXIT1_IR: begin
                nxt = tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PAUSE_IR;
            end
            sbst_pkg::ST_PAUSE_IR: begin
                nxt = tms ? sbst_pkg::ST_EXIT2_IR : sbst_pkg::ST_PAUSE_IR;
            end
            sbst_pkg::ST_EXIT2_IR: begin
                nxt = tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SHIFT_IR;
            end
            sbst_pkg::ST_UPD_IR: begin
                nxt = tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
            end
            default: begin
                nxt = sbst_pkg::ST_RESET;
            end
        endcase
        return nxt;
    endfunction

    // instruction decode to the one data register it selects
    function automatic sbst_pkg::sbst_sel_t decode_sel(input logic [2:0] ins);
        sbst_pkg::sbst_sel_t sel;
        sel = sbst_pkg::SEL_BYPASS;
        case (ins)
            sbst_pkg::INS_EXTEST: begin
                sel = sbst_pkg::SEL_BSR;
            end
            sbst_pkg::INS_IDCODE: begin
                sel = sbst_pkg::SEL_ID;
            end
            sbst_pkg::INS_SAMPLE_Z: begin
                sel = sbst_pkg::SEL_BSR;
            end
            sbst_pkg::INS_PRELOAD: begin
                sel = sbst_pkg::SEL_BSR;
            end
            default: begin
                // reserved codes have no behaviour; they fall to bypass so the
                // chain length stays defined if one is loaded anyway
                sel = sbst_pkg::SEL_BYPASS;
            end
        endcase
        return sel;
    endfunction

    assign dr_sel = decode_sel(ir_active);
    assign bsr_update_ok = (ir_active == sbst_pkg::INS_EXTEST)
                         || (ir_active == sbst_pkg::INS_PRELOAD);

    // state machine, test-clock rise only
    always_comb begin
        next_state = tap_next(state, tms_s);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= sbst_pkg::ST_RESET;
        end else if (tck_rise) begin
            // five highs reach reset from any state
            state <= next_state;
        end
    end

    // instruction shift stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_shift <= sbst_pkg::INS_IDCODE;
        end else if (tck_rise) begin
            case (state)
                sbst_pkg::ST_CAP_IR: begin
                    ir_shift <= {ir_shift[2], sbst_pkg::IR_CAPTURE};
                end
                sbst_pkg::ST_SHIFT_IR: begin
                    ir_shift <= {tdi_s, ir_shift[2:1]};
                end
                default: begin
                    ir_shift <= ir_shift;
                end
            endcase
        end
    end

    // active instruction
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ir_active <= sbst_pkg::INS_IDCODE;
        end else if (state == sbst_pkg::ST_RESET) begin
            ir_active <= sbst_pkg::INS_IDCODE;
        end else if (tck_rise && state == sbst_pkg::ST_UPD_IR) begin
            ir_active <= ir_shift;
        end
    end

    // bypass bit
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bypass_bit <= 1'b0;
        end else if (tck_rise && dr_sel == sbst_pkg::SEL_BYPASS) begin
            if (state == sbst_pkg::ST_CAP_DR) begin
                bypass_bit <= 1'b0;
            end else if (state == sbst_pkg::ST_SHIFT_DR) begin
                bypass_bit <= tdi_s;
            end
        end
    end

    // identification register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            id_shift <= '0;
        end else if (tck_rise && dr_sel == sbst_pkg::SEL_ID) begin
            if (state == sbst_pkg::ST_CAP_DR) begin
                id_shift <= ID_VALUE;
            end else if (state == sbst_pkg::ST_SHIFT_DR) begin
                id_shift <= {tdi_s, id_shift[sbst_pkg::ID_LEN-1:1]};
            end
        end
    end

    // boundary scan shift stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bsr_shift <= '0;
        end else if (tck_rise && dr_sel == sbst_pkg::SEL_BSR) begin
            if (state == sbst_pkg::ST_CAP_DR) begin
                // snapshot only; memory traffic is never touched
                bsr_shift <= ring_s;
            end else if (state == sbst_pkg::ST_SHIFT_DR) begin
                // old capture leaves at the lsb while preload enters at the msb
                bsr_shift <= {tdi_s, bsr_shift[BSR_W-1:1]};
            end
        end
    end

    // boundary parallel latches
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bsr_latch <= '0;
            bsr_latch[sbst_pkg::OE_CELL] <= 1'b1;
        end else if (state == sbst_pkg::ST_RESET) begin
            bsr_latch[sbst_pkg::OE_CELL] <= 1'b1;
        end else if (tck_rise && state == sbst_pkg::ST_UPD_DR && bsr_update_ok) begin
            bsr_latch <= bsr_shift;
        end
    end

    // serial output source, lsb of the selected register
    always_comb begin
        next_tdo = 1'b0;
        if (state == sbst_pkg::ST_SHIFT_IR) begin
            next_tdo = ir_shift[0];
        end else begin
            case (dr_sel)
                sbst_pkg::SEL_ID: begin
                    next_tdo = id_shift[0];
                end
                sbst_pkg::SEL_BSR: begin
                    next_tdo = bsr_shift[0];
                end
                default: begin
                    next_tdo = bypass_bit;
                end
            endcase
        end
    end

    // serial output, test-clock fall only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            test_data_out <= 1'b0;
            test_data_out_oe_n <= 1'b1;
        end else if (tck_fall) begin
            test_data_out <= next_tdo;
            test_data_out_oe_n <= !(state == sbst_pkg::ST_SHIFT_IR
                                 || state == sbst_pkg::ST_SHIFT_DR);
        end
    end

    // pin ring control; reset only changes what the test port drives, so
    // with the identification instruction the memory runs as normal
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ring_drive <= 1'b0;
            ring_hiz <= 1'b0;
            ring_preload <= '0;
            active_instr <= sbst_pkg::INS_IDCODE;
        end else begin
            ring_preload <= bsr_latch;
            active_instr <= ir_active;
            case (ir_active)
                sbst_pkg::INS_EXTEST: begin
                    ring_drive <= bsr_latch[sbst_pkg::OE_CELL];
                    ring_hiz <= !bsr_latch[sbst_pkg::OE_CELL];
                end
                sbst_pkg::INS_SAMPLE_Z: begin
                    ring_drive <= 1'b0;
                    ring_hiz <= 1'b1;
                end
                default: begin
                    ring_drive <= 1'b0;
                    ring_hiz <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: sim/sbst_jtag_host.sv
/*
 * behavioural scan controller driving the tap's test pins.
 * assumes the caller starts each scan from run-test-idle.
 */
`timescale 1ns/1ps
module sbst_jtag_host (
    output logic test_clk,
    output logic test_mode_sel,
    output logic test_data_in,
    input wire logic test_data_out,
    input wire logic test_data_out_oe_n
);
    // 125 ns period keeps the test clock under its ceiling
    localparam realtime HALF = 62.5;
    // data in idles high like its pull-up; clock stands low between frames
    initial begin
        test_clk = 1'b0;
        test_mode_sel = 1'b1;
        test_data_in = 1'b1;
    end
    // pins change at the fall, half a period clear of the sampling rise
    task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
        test_mode_sel = tms;
        test_data_in = tdi;
        #(HALF);
        // serial out has no pull; an undriven pin reads back inverted so a
        // missing enable shows up as wrong data
        tdo = test_data_out_oe_n ? !test_data_out : test_data_out;
        oe_n = test_data_out_oe_n;
        test_clk = 1'b1;
        #(HALF);
        test_clk = 1'b0;
    endtask
    task automatic reset5();
        logic d;
        logic o;
        repeat (5) step(1'b1, 1'b1, d, o);
        step(1'b0, 1'b1, d, o);
    endtask
    // lsb leaves first; ends in run-test-idle after the update state
    task automatic scan(input logic ir, input int len, input logic [127:0] din,
                        output logic [127:0] dout, output logic oe_any);
        logic d;
        logic o;
        dout = '0;
        oe_any = 1'b0;
        step(1'b1, 1'b1, d, o);
        if (ir) begin
            step(1'b1, 1'b1, d, o);
        end
        step(1'b0, 1'b1, d, o);
        step(1'b0, 1'b1, d, o);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, din[i], d, o);
            dout[i] = d;
            oe_any = oe_any | o;
        end
        step(1'b1, 1'b1, d, o);
        step(1'b0, 1'b1, d, o);
    endtask
endmodule

// File: sim/sbst_tap_bench.sv
/*
 * self-checking bench for sbst_tap: a table of instructions, then reset cases.
 * assumes sbst_jtag_host as controller and the property bind compiled in.
 */
`timescale 1ns/1ps
module sbst_tap_bench;
    localparam int L = sbst_pkg::BSR_LEN;
    // identity value is arbitrary
    localparam logic [31:0] ID_TB = 32'h5E2D_9B47;
    typedef struct {
        logic [2:0] code;
        int len;
        logic hiz;
    } sbst_row_t;
    // extest floats because the preload row latches a zero oe cell; no reserved code
    sbst_row_t rows [5] = '{
        '{sbst_pkg::INS_IDCODE, 32, 1'b0}, '{sbst_pkg::INS_BYPASS, 1, 1'b0},
        '{sbst_pkg::INS_SAMPLE_Z, L, 1'b1}, '{sbst_pkg::INS_PRELOAD, L, 1'b0},
        '{sbst_pkg::INS_EXTEST, L, 1'b1}};
    logic clk = 1'b0;
    logic arst_n;
    logic test_clk, test_mode_sel, test_data_in, test_data_out, test_data_out_oe_n;
    logic [L-1:0] ring_in;
    logic [L-1:0] ring_preload;
    logic ring_drive, ring_hiz;
    logic [2:0] active_instr;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    sbst_tap #(.BSR_W(L), .ID_VALUE(ID_TB)) u_dut (
        .clk(clk), .arst_n(arst_n), .test_clk(test_clk), .test_mode_sel(test_mode_sel),
        .test_data_in(test_data_in), .ring_in(ring_in), .test_data_out(test_data_out),
        .test_data_out_oe_n(test_data_out_oe_n), .ring_preload(ring_preload),
        .ring_drive(ring_drive), .ring_hiz(ring_hiz), .active_instr(active_instr));
    sbst_jtag_host u_host (
        .test_clk(test_clk), .test_mode_sel(test_mode_sel), .test_data_in(test_data_in),
        .test_data_out(test_data_out), .test_data_out_oe_n(test_data_out_oe_n));
    always #5 clk = ~clk;
    task automatic check(input string name, input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // the whole run needs about 7150 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end
    initial begin
        logic [127:0] din, dout, cap;
        logic [L-1:0] exp_pl;
        logic oe_any;
        int ln;
        arst_n = 1'b0;
        ring_in = 85'h1A_5A5A_C3C3_F0F0_1234_5678;
        // 93 shifts leave din[92:8] in the chain; bit 92 is zero so the oe cell clears
        din = 128'h9E37_79B9_6F4A_7C15_C2B2_AE35_8765_4321;
        exp_pl = {1'b1, 84'h0};
        repeat (3) @(posedge clk);
        #1;
        check("oe_n in reset", 128'(test_data_out_oe_n), 128'h1);
        check("instr in reset", 128'(active_instr), 128'(sbst_pkg::INS_IDCODE));
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1 check("oe cell at power-up", 128'(ring_preload), 128'(exp_pl));
        u_host.reset5();
        foreach (rows[r]) begin
            ln = rows[r].len;
            u_host.scan(1'b1, 3, 128'(rows[r].code), dout, oe_any);
            check("ir capture", 128'(dout[1:0]), 128'h1);
            check("instr", 128'(active_instr), 128'(rows[r].code));
            check("hiz", 128'(ring_hiz), 128'(rows[r].hiz));
            check("drive", 128'(ring_drive), 128'h0);
            cap = (ln == 32) ? 128'(ID_TB) : (ln == 1) ? 128'h0 : 128'(ring_in);
            u_host.scan(1'b0, L + 8, din, dout, oe_any);
            check("captured", dout & ((128'h1 << ln) - 128'h1), cap);
            check("passed", 128'(8'(dout >> ln)), 128'(din[7:0]));
            check("oe_n in shift", 128'(oe_any), 128'h0);
            check("oe_n idle", 128'(test_data_out_oe_n), 128'h1);
            if (rows[r].code == sbst_pkg::INS_EXTEST || rows[r].code == sbst_pkg::INS_PRELOAD) begin
                exp_pl = din[L+7:8];
            end
            check("latches", 128'(ring_preload), 128'(exp_pl));
            check("hiz after dr", 128'(ring_hiz), 128'(rows[r].hiz));
        end
        u_host.reset5();
        check("instr after tap reset", 128'(active_instr), 128'(sbst_pkg::INS_IDCODE));
        check("oe cell after tap reset", 128'(ring_preload), 128'({1'b1, din[L+6:8]}));
        u_host.scan(1'b1, 3, 128'(sbst_pkg::INS_EXTEST), dout, oe_any);
        check("extest drive", 128'({ring_drive, ring_hiz}), 128'h2);
        @(posedge clk);
        #1 arst_n = 1'b0;
        #1 check("mid-run reset", 128'({ring_drive, ring_hiz, active_instr}), 128'h1);
        @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("late oe cell", 128'(ring_preload), 128'({1'b1, 84'h0}));
        check("late oe_n", 128'(test_data_out_oe_n), 128'h1);
        u_host.reset5();
        u_host.scan(1'b1, 3, 128'(sbst_pkg::INS_BYPASS), dout, oe_any);
        check("late ir capture", 128'(dout[1:0]), 128'h1);
        check("late instr", 128'(active_instr), 128'(sbst_pkg::INS_BYPASS));
        results();
    end
endmodule

// File: sim/sbst_tap_properties.sv
/*
 * port checks for sbst_tap, bound onto every instance.
 * assumes the test clock is far slower than clk, as the tap does.
 */
`timescale 1ns/1ps
module sbst_tap_props #(
    parameter int BSR_W = sbst_pkg::BSR_LEN
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic test_clk,
    input wire logic test_mode_sel,
    input wire logic test_data_in,
    input wire logic [BSR_W-1:0] ring_in,
    input wire logic test_data_out,
    input wire logic test_data_out_oe_n,
    input wire logic [BSR_W-1:0] ring_preload,
    input wire logic ring_drive,
    input wire logic ring_hiz,
    input wire logic [2:0] active_instr
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    // rises seen with mode select high; saturates so a long hold stays counted
    logic [2:0] hi_cnt;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hi_cnt <= 3'h0;
        end else if ($rose(test_clk)) begin
            hi_cnt <= !test_mode_sel ? 3'h0 : (hi_cnt == 3'h5) ? 3'h5 : hi_cnt + 3'h1;
        end
    end
    a_tdo_on_fall: assert property (
        $changed(test_data_out) |-> !test_clk)
        else $error("serial out moved with test clock high");
    a_oe_on_fall: assert property (
        $changed(test_data_out_oe_n) |-> !test_clk)
        else $error("serial out enable moved with test clock high");
    a_instr_on_rise: assert property (
        $changed(active_instr) |-> test_clk)
        else $error("instruction changed away from a rise");
    a_latch_on_rise: assert property (
        $changed(ring_preload) && $past(arst_n, 2) |-> test_clk)
        else $error("boundary latches changed away from a rise");
    a_drive_hiz_excl: assert property (
        !(ring_drive && ring_hiz))
        else $error("pins driven and floated together");
    a_drive_cause: assert property (
        ring_drive && $stable(ring_drive) && $stable(active_instr)
        |-> active_instr == sbst_pkg::INS_EXTEST && ring_preload[BSR_W-1])
        else $error("pins driven without extest and oe cell");
    a_sample_z_float: assert property (
        active_instr == sbst_pkg::INS_SAMPLE_Z && $stable(active_instr)
        |-> ring_hiz && !ring_drive)
        else $error("sample-z left outputs enabled");
    a_quiet_modes: assert property (
        (active_instr == sbst_pkg::INS_PRELOAD || active_instr == sbst_pkg::INS_IDCODE)
        && $stable(active_instr) |-> !ring_hiz && !ring_drive)
        else $error("memory pins disturbed");
    a_reset_values: assert property (
        $rose(arst_n) |-> (test_data_out_oe_n && active_instr == sbst_pkg::INS_IDCODE)
        ##1 ring_preload[BSR_W-1])
        else $error("wrong state after reset");
    a_tms_reset: assert property (
        $rose(test_clk) && test_mode_sel && hi_cnt >= 3'h4 |-> ##[4:8]
        (active_instr == sbst_pkg::INS_IDCODE && ring_preload[BSR_W-1] && test_data_out_oe_n))
        else $error("five high rises did not reset the tap");
endmodule

bind sbst_tap sbst_tap_props #(.BSR_W(BSR_W)) u_props (
    .clk(clk), .arst_n(arst_n), .test_clk(test_clk), .test_mode_sel(test_mode_sel),
    .test_data_in(test_data_in), .ring_in(ring_in), .test_data_out(test_data_out),
    .test_data_out_oe_n(test_data_out_oe_n), .ring_preload(ring_preload),
    .ring_drive(ring_drive), .ring_hiz(ring_hiz), .active_instr(active_instr));
